// ### hdl/bmiod_pkg.sv
// Package of constants and carrier types for the board memory and I/O decoder.
package bmiod_pkg;

	localparam int MEM_ADDR_WIDTH = 20;
	localparam int IO_ADDR_WIDTH  = 16;
	localparam int IO_GROUPS      = 8;
	localparam int GROUP_LSB      = 6;
	localparam int GROUP_MSB      = 8;
	localparam int BANK_LSB       = 9;
	localparam int BANK_MSB       = 10;
	localparam int MEM_NIB_LSB    = 16;

	// Top nibble of the memory address at the first (LO) and last (HI) step of each window.
	localparam logic [3:0] SMALL_ROM_LO  = 4'h0;
	localparam logic [3:0] SMALL_ROM_HI  = 4'h1;
	localparam logic [3:0] SMALL_RAM1_LO = 4'h2;
	localparam logic [3:0] SMALL_RAM1_HI = 4'h3;
	localparam logic [3:0] SMALL_RAM2_LO = 4'h8;
	localparam logic [3:0] SMALL_RAM2_HI = 4'h9;
	localparam logic [3:0] SMALL_RAM3_LO = 4'hA;
	localparam logic [3:0] SMALL_RAM3_HI = 4'hB;
	localparam logic [3:0] LARGE_ROM_HI  = 4'h7;
	localparam logic [3:0] LARGE_RAM_LO  = 4'h8;

	// Value of A10:A9 for which the group decode is enabled.
	localparam logic [1:0] IO_BANK_ENABLED = 2'h0;

	// Number of input flip-flops on the reset pin.
	localparam int RESET_SYNC_STAGES = 3;

	typedef struct packed {
		logic       rom_n;
		logic       ram1_n;
		logic       ram2_n;
		logic       ram3_n;
	} bmiod_mem_sel_type;

	typedef struct packed {
		logic [MEM_ADDR_WIDTH-1:0] mem_addr;
		logic [IO_ADDR_WIDTH-1:0]  io_addr;
		logic                      mem_strobe_n;
		logic                      io_cycle_strobe_n;
	} bmiod_bus_type;

endpackage : bmiod_pkg

// ### hdl/bmiod_reset_sync.sv
// Three-stage input filter for the external active-low reset pin.
`timescale 1ns/1ps

module bmiod_reset_sync
	import bmiod_pkg::*;
(
	input  wire logic clock,          // System clock.
	input  wire logic reset,          // Synchronous reset, active high.
	input  wire logic pin_reset_n,    // Raw reset pin, low to reset.
	output logic      board_reset     // Filtered reset, active high.
);

	logic [RESET_SYNC_STAGES-1:0] sync_reg;
	logic                         board_reset_reg;

	// Shift the pin through three flops; only stage two and three are compared.
	always_ff @(posedge clock) begin
		if (reset) begin
			sync_reg <= '1;
		end else begin
			sync_reg <= {sync_reg[RESET_SYNC_STAGES-2:0], pin_reset_n};
		end
	end

	// Change the output only when the last two stages agree.
	always_ff @(posedge clock) begin
		if (reset) begin
			board_reset_reg <= 1'b0;
		end else if (sync_reg[1] == sync_reg[2]) begin
			board_reset_reg <= ~sync_reg[2];
		end
	end

	assign board_reset = board_reset_reg;

endmodule : bmiod_reset_sync

// ### hdl/bmiod_decoder.sv
// Top module: memory and I/O chip-select decoder with registered outputs.
`timescale 1ns/1ps

module bmiod_decoder
	import bmiod_pkg::*;
(
	input  wire logic                     clock,             // System clock, 40 MHz.
	input  wire logic                     reset,             // Synchronous reset, active high.
	input  wire logic [MEM_ADDR_WIDTH-1:0] mem_addr,         // Memory address A0..A19.
	input  wire logic                     mem_strobe_n,      // Memory cycle strobe, active low.
	input  wire logic [IO_ADDR_WIDTH-1:0] io_addr,           // I/O address A0..A15.
	input  wire logic                     io_cycle_strobe_n, // I/O cycle strobe, active low.
	input  wire logic                     map_size_jumpers,  // 1 selects the large map.
	input  wire logic                     ram_size_jumper,   // Not decoded; 1 with the small map sets config_error.
	input  wire logic                     reset_screw_terminal_n, // External reset pin.
	output logic                          rom_sel_n,         // ROM socket select.
	output logic                          ram1_sel_n,        // First RAM socket select.
	output logic                          ram2_sel_n,        // Second RAM socket select.
	output logic                          ram3_sel_n,        // Third RAM socket select.
	output logic [IO_GROUPS-1:0]          io_group_sel_n,    // I/O group selects.
	output logic                          board_reset_out,   // Filtered reset, active high.
	output logic                          config_error       // Illegal jumper combination.
);

	bmiod_bus_type     bus;
	bmiod_mem_sel_type mem_next;
	logic [IO_GROUPS-1:0] io_next;
	logic              board_reset;

	bmiod_mem_sel_type    mem_reg;
	logic [IO_GROUPS-1:0] io_reg;
	logic                 board_reset_reg;
	logic                 config_error_reg;

	// Returns true when the nibble lies in the inclusive window.
	function automatic logic in_window(input logic [3:0] nib, input logic [3:0] lo,
	                                   input logic [3:0] hi);
		in_window = (nib >= lo) && (nib <= hi);
	endfunction : in_window

	assign bus = '{mem_addr: mem_addr, io_addr: io_addr, mem_strobe_n: mem_strobe_n,
	               io_cycle_strobe_n: io_cycle_strobe_n};

	bmiod_reset_sync u_reset_sync (
		.clock       (clock),
		.reset       (reset),
		.pin_reset_n (reset_screw_terminal_n),
		.board_reset (board_reset)
	);

	// Memory select decode from the top address nibble and the map jumpers.
	always_comb begin
		logic [3:0] nib;
		logic       active;
		nib      = bus.mem_addr[MEM_ADDR_WIDTH-1:MEM_NIB_LSB];
		active   = ~bus.mem_strobe_n;
		mem_next = '{rom_n: 1'b1, ram1_n: 1'b1, ram2_n: 1'b1, ram3_n: 1'b1};
		if (active && map_size_jumpers) begin
			mem_next.rom_n  = ~in_window(nib, SMALL_ROM_LO, LARGE_ROM_HI);
			mem_next.ram1_n = ~in_window(nib, LARGE_RAM_LO, 4'hF);
			// The second and third RAM stay quiet here so one select asserts.
		end else if (active) begin
			mem_next.rom_n  = ~in_window(nib, SMALL_ROM_LO, SMALL_ROM_HI);
			mem_next.ram1_n = ~in_window(nib, SMALL_RAM1_LO, SMALL_RAM1_HI);
			mem_next.ram2_n = ~in_window(nib, SMALL_RAM2_LO, SMALL_RAM2_HI);
			mem_next.ram3_n = ~in_window(nib, SMALL_RAM3_LO, SMALL_RAM3_HI);
		end
	end

	// I/O group decode from A6..A8, enabled by A9..A10 and the I/O strobe.
	always_comb begin
		logic [2:0] group;
		logic       enable;
		group   = bus.io_addr[GROUP_MSB:GROUP_LSB];
		enable  = ~bus.io_cycle_strobe_n
		        && (bus.io_addr[BANK_MSB:BANK_LSB] == IO_BANK_ENABLED);
		io_next = '1;
		if (enable) begin
			io_next[group] = 1'b0;
		end
		io_next[0] = 1'b1;  // The lowest group serves no device.
	end

	// Register the memory selects.
	always_ff @(posedge clock) begin
		if (reset) begin
			mem_reg <= '{rom_n: 1'b1, ram1_n: 1'b1, ram2_n: 1'b1, ram3_n: 1'b1};
		end else begin
			mem_reg <= mem_next;
		end
	end

	// Register the I/O group selects.
	always_ff @(posedge clock) begin
		if (reset) begin
			io_reg <= '1;
		end else begin
			io_reg <= io_next;
		end
	end

	// Register the reset and jumper check outputs.
	always_ff @(posedge clock) begin
		if (reset) begin
			board_reset_reg  <= 1'b0;
			config_error_reg <= 1'b0;
		end else begin
			board_reset_reg  <= board_reset;
			config_error_reg <= ram_size_jumper & ~map_size_jumpers;
		end
	end

	assign rom_sel_n       = mem_reg.rom_n;
	assign ram1_sel_n      = mem_reg.ram1_n;
	assign ram2_sel_n      = mem_reg.ram2_n;
	assign ram3_sel_n      = mem_reg.ram3_n;
	assign io_group_sel_n  = io_reg;
	assign board_reset_out = board_reset_reg;
	assign config_error    = config_error_reg;

	// Checks on the registered selects; each implication looks one edge after the inputs it decodes.
	property p_one_mem;
		@(posedge clock) disable iff (reset)
		$countones({~rom_sel_n, ~ram1_sel_n, ~ram2_sel_n, ~ram3_sel_n}) <= 1;
	endproperty

	// Two memory selects at once would make two sockets fight over the data bus.
	chk_one_mem_sel: assert property (p_one_mem) else $error("two memory selects");

	// Reset leaves every select high, so no socket sees a cycle while the board starts.
	chk_reset_quiet: assert property (@(posedge clock)
		reset |=> rom_sel_n && ram1_sel_n && ram2_sel_n && ram3_sel_n
		&& (io_group_sel_n == '1) && !board_reset_out && !config_error)
		else $error("select active after reset");

	// Memory decode: no select without the strobe, then each window of each map.
	chk_mem_strobe_qual: assert property (@(posedge clock) disable iff (reset)
		mem_strobe_n |=> rom_sel_n && ram1_sel_n && ram2_sel_n && ram3_sel_n)
		else $error("memory select without strobe");

	chk_small_rom_map: assert property (@(posedge clock) disable iff (reset)
		(!mem_strobe_n && !map_size_jumpers && mem_addr[19:17] == 3'h0)
		|=> !rom_sel_n) else $error("small map rom miss");

	chk_small_ram1_map: assert property (@(posedge clock) disable iff (reset)
		(!mem_strobe_n && !map_size_jumpers && mem_addr[19:17] == 3'h1)
		|=> !ram1_sel_n && rom_sel_n) else $error("small map ram1 miss");

	chk_small_ram2_map: assert property (@(posedge clock) disable iff (reset)
		(!mem_strobe_n && !map_size_jumpers && mem_addr[19:17] == 3'h4)
		|=> !ram2_sel_n && ram3_sel_n) else $error("small map ram2 miss");

	chk_small_ram3_map: assert property (@(posedge clock) disable iff (reset)
		(!mem_strobe_n && !map_size_jumpers && mem_addr[19:17] == 3'h5)
		|=> !ram3_sel_n && rom_sel_n) else $error("small map ram3 miss");

	// Nibbles 4 to 7 and C to F hold no socket in the small map.
	chk_small_gap_quiet: assert property (@(posedge clock) disable iff (reset)
		(!mem_strobe_n && !map_size_jumpers && mem_addr[18])
		|=> rom_sel_n && ram1_sel_n && ram2_sel_n && ram3_sel_n)
		else $error("small map gap selected");

	chk_large_rom_map: assert property (@(posedge clock) disable iff (reset)
		(!mem_strobe_n && map_size_jumpers && !mem_addr[19])
		|=> !rom_sel_n && ram1_sel_n) else $error("large map rom miss");

	chk_large_ram_map: assert property (@(posedge clock) disable iff (reset)
		(!mem_strobe_n && map_size_jumpers && mem_addr[19])
		|=> !ram1_sel_n && ram2_sel_n && ram3_sel_n) else $error("large map ram miss");

	// I/O decode: the lowest group and the reserved range never reach a device.
	chk_low_group_off: assert property (@(posedge clock) disable iff (reset)
		io_group_sel_n[0]) else $error("lowest group asserted");

	chk_reserved_io_quiet: assert property (@(posedge clock) disable iff (reset)
		(io_addr[10:6] == 5'h00) |=> (io_group_sel_n == '1))
		else $error("reserved io selected");

	chk_io_strobe_qual: assert property (@(posedge clock) disable iff (reset)
		io_cycle_strobe_n |=> (io_group_sel_n == '1))
		else $error("io select without strobe");

	chk_io_bank_off: assert property (@(posedge clock) disable iff (reset)
		(io_addr[10:9] != 2'h0) |=> (io_group_sel_n == '1))
		else $error("io select in user range");

	chk_io_group_hit: assert property (@(posedge clock) disable iff (reset)
		(!io_cycle_strobe_n && io_addr[10:9] == 2'h0 && io_addr[8:6] == 3'h5)
		|=> !io_group_sel_n[5] && $countones(~io_group_sel_n) == 1)
		else $error("io group miss");

	// A group select does not move while only A0 to A5 change.
	chk_io_low_ignored: assert property (@(posedge clock) disable iff (reset)
		(!$past(reset) && !io_cycle_strobe_n && !$past(io_cycle_strobe_n)
		&& io_addr[10:6] == $past(io_addr[10:6])) |=> $stable(io_group_sel_n))
		else $error("group moved inside a block");

	// Jumper check: the flag follows the illegal pair and nothing else.
	chk_jumper_flag: assert property (@(posedge clock) disable iff (reset)
		(ram_size_jumper && !map_size_jumpers) |=> config_error)
		else $error("jumper error missed");

	chk_jumper_clear: assert property (@(posedge clock) disable iff (reset)
		(!ram_size_jumper || map_size_jumpers) |=> !config_error)
		else $error("jumper error raised");

	// The pin filter needs five edges to follow the pin either way.
	// A shorter glitch may or may not pass, so only the long runs are checked.
	chk_pin_reset_assert: assert property (@(posedge clock) disable iff (reset)
		(!reset_screw_terminal_n [*5]) |=> board_reset_out)
		else $error("board reset missed");

	chk_pin_reset_release: assert property (@(posedge clock) disable iff (reset)
		(reset_screw_terminal_n [*5]) |=> !board_reset_out)
		else $error("board reset stuck");

	// Main scenarios that the tests are expected to reach.
	cov_small_ram2: cover property (@(posedge clock) !ram2_sel_n);
	cov_large_rom: cover property (@(posedge clock) map_size_jumpers && !rom_sel_n);
	cov_io_group7: cover property (@(posedge clock) !io_group_sel_n[7]);
	cov_board_reset: cover property (@(posedge clock) board_reset_out);
	cov_jumper_error: cover property (@(posedge clock) config_error);

endmodule : bmiod_decoder

// ### test/bmiod_cpu_model.sv
// Processor bus model that drives the memory and I/O cycles seen by the decoder.
`timescale 1ns/1ps

module bmiod_cpu_model
	import bmiod_pkg::*;
(
	input  wire bmiod_bus_type req, // Cycle asked for by the bench.
	input  wire logic          clock, // System clock.
	output bmiod_bus_type      bus  // Bus as the decoder sees it.
);
	initial bus = '0;

	// Launches each cycle after the edge; an idle address shows the inverse of the last one,
	// so a decoder that ignores its strobe cannot be saved by stale address lines.
	always @(posedge clock) begin
		bus.mem_strobe_n <= req.mem_strobe_n;
		bus.io_cycle_strobe_n <= req.io_cycle_strobe_n;
		bus.mem_addr <= req.mem_strobe_n ? ~bus.mem_addr : req.mem_addr;
		bus.io_addr <= req.io_cycle_strobe_n ? ~bus.io_addr : req.io_addr;
	end
endmodule : bmiod_cpu_model

// ### test/tb_top.sv
// Self-checking bench for the board memory and I/O decoder.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
	import bmiod_pkg::*;
	logic          clock = 0;
	logic          reset = 1;
	logic          map_size = 0;
	logic          ram_size = 0;
	logic          pin_n = 1;
	bmiod_bus_type req = '{20'h0, 16'h0, 1'b1, 1'b1};
	bmiod_bus_type bus;
	wire logic [3:0] mem_sel;
	wire logic [7:0] io_sel;
	wire logic     board_rst;
	wire logic     cfg_err;
	logic [3:0]    exp_mem;
	logic [7:0]    exp_io;
	logic          exp_cfg;
	logic [1:0]    jmp;
	logic          cmp_on = 0;
	int            bad_count = 0;
	int            checked = 0;
	logic [15:0]   io_tab [10] = '{16'h0000, 16'h003F, 16'h0040, 16'h007F, 16'h0140,
		16'h01FF, 16'h0200, 16'h07FF, 16'h0800, 16'hF9C0};

	always #12.5 clock = ~clock;

	bmiod_cpu_model bmiod_cpu_model_i (.clock(clock), .req(req), .bus(bus));
	bmiod_decoder bmiod_decoder_i (
		.clock(clock), .reset(reset), .mem_addr(bus.mem_addr),
		.mem_strobe_n(bus.mem_strobe_n), .io_addr(bus.io_addr),
		.io_cycle_strobe_n(bus.io_cycle_strobe_n), .map_size_jumpers(map_size),
		.ram_size_jumper(ram_size), .reset_screw_terminal_n(pin_n),
		.rom_sel_n(mem_sel[3]), .ram1_sel_n(mem_sel[2]), .ram2_sel_n(mem_sel[1]),
		.ram3_sel_n(mem_sel[0]), .io_group_sel_n(io_sel),
		.board_reset_out(board_rst), .config_error(cfg_err));

	// Reference decode: memory selects as {rom, ram1, ram2, ram3}, then the eight groups.
	function automatic logic [11:0] model(bmiod_bus_type b, logic big);
		int nib;
		logic [3:0] m;
		logic [7:0] g;
		nib = b.mem_addr[19:16];
		m = 4'hF;
		g = 8'hFF;
		if (!b.mem_strobe_n && big) m = (nib < 8) ? 4'h7 : 4'hB;
		else if (!b.mem_strobe_n) m = nib < 2 ? 4'h7 : nib < 4 ? 4'hB : nib < 8 ? 4'hF :
			nib < 10 ? 4'hD : nib < 12 ? 4'hE : 4'hF;
		if (!b.io_cycle_strobe_n && b.io_addr[10:9] == 2'h0) g[b.io_addr[8:6]] = 1'b0;
		g[0] = 1'b1;
		return {m, g};
	endfunction : model

	// Expected outputs follow the inputs sampled at each edge by one cycle.
	always @(posedge clock) begin
		{exp_mem, exp_io} <= reset ? 12'hFFF : model(bus, map_size);
		exp_cfg <= !reset && ram_size && !map_size;
		cmp_on <= 1'b1;
	end

	// Every settled select and the jumper flag are compared with the reference.
	always @(negedge clock) begin
		if (cmp_on) begin
			`CHK(mem_sel, exp_mem)
			`CHK(io_sel, exp_io)
			`CHK($countones(~mem_sel) <= 1, 1'b1)
			`CHK(cfg_err, exp_cfg)
		end
	end

	task automatic cyc(logic [19:0] ma, logic ms, logic [15:0] ia, logic is);
		req <= '{ma, ia, ms, is};
		@(posedge clock);
	endtask : cyc

	task automatic test_done();
		if (bad_count == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done

	// Stops a hung run well after the tests should have ended.
	initial begin
		repeat (6000) @(posedge clock);
		bad_count++;
		test_done();
	end

	initial begin
		void'($urandom(54));
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		// Both ends of every memory nibble in each map; the RAM size jumper follows the map jumper.
		for (int big = 0; big < 2; big++) begin
			map_size <= big[0];
			ram_size <= big[0];
			for (int n = 0; n < 16; n++) begin
				cyc({n[3:0], 16'hFFFF}, 1'b0, 16'h0, 1'b1);
				cyc({n[3:0], 16'h0000}, 1'b0, 16'h0, 1'b1);
			end
			cyc(20'h0, 1'b1, 16'h0, 1'b1);
		end
		// Group boundaries back to back, then released.
		foreach (io_tab[i]) cyc(20'h0, 1'b1, io_tab[i], 1'b0);
		cyc(20'h0, 1'b1, 16'h0, 1'b1);
		// Random cycles with the jumpers held within each block and redrawn at random between blocks.
		repeat (10) begin
			jmp = 2'($urandom);
			map_size <= jmp[1];
			ram_size <= jmp[1] & jmp[0];
			repeat (200) cyc(20'($urandom), 1'($urandom), 16'($urandom), 1'($urandom));
		end
		// Illegal jumper pair is flagged.
		map_size <= 1'b0;
		ram_size <= 1'b1;
		repeat (3) cyc(20'h0, 1'b1, 16'h0, 1'b1);
		ram_size <= 1'b0;
		// External reset pulled low, then let go.
		pin_n <= 1'b0;
		repeat (4) @(posedge clock);
		#1 `CHK(board_rst, 1'b0)
		@(posedge clock);
		pin_n <= 1'b1;
		#1 `CHK(board_rst, 1'b1)
		repeat (4) @(posedge clock);
		#1 `CHK(board_rst, 1'b1)
		@(posedge clock);
		#1 `CHK(board_rst, 1'b0)
		test_done();
	end
endmodule : tb_top
